// ### design/tdcf_word_formatter.sv
/*
 * Readout word formatter: builds typed 32-bit words for each event and
 * sends them on a parallel valid/ready port or on a framed serial line.
 * Assumes an upstream matcher that offers one event record, then its
 * measurements (last flagged), and a single synchronous 10 MHz clock.
 */
// The register offsets and register access over AXI4-Lite were decided locally.
// What this block does
// - every readout unit is a 32-bit word; parallel mode gives one per clock
// - serial mode shifts each word out one bit at a time
// - bits 31 to 28 hold the word type code
// - bits 27 to 24 hold the programmed chip identifier
// - only seven type codes are ever emitted, nine stay reserved
// - header is type 1010 with event number and bunch number
// - trailer is type 1100 with event number and word count incl. itself
// - channel flag word is type 0010, one bit per channel with hits
// - single-edge word is 0011 with channel, edge, error, coarse, fine
// - coarse counts 25 ns bins, fine counts 25 ns over 32
// - edge bit is 1 for leading and 0 for trailing
// - hit error bit is coarse, channel-select or reject error
// - paired word is 0100 with channel, width, leading coarse and fine
// - width uses chosen resolution, saturates at FF, rollover gives 00
// - error word is 0110 with flags in the low field
// - separator debug word is 0111, sub-code 0000, bunch tag low
// - occupancy debug word is 0111, sub-code 0001, full bit and level
// - order: header, hard error, data, flags, temporal error, trailer, debug
// - each word class is gated by its own control bits
// - serial frame: start one, 32 data, even parity, two stop bits
// - select bit 0 uses the parallel bus, 1 the serial link
`include "tdcf_params.svh"

module tdcf_word_formatter (
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic [3:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [3:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire tdcf_pkg::tdcf_event_t evInfo,
    input  wire logic                 evValid,
    output logic                      evReady,
    input  wire tdcf_pkg::tdcf_hit_t  hit,
    input  wire logic                 hitValid,
    output logic                      hitReady,
    output logic [31:0]               parWord,
    output logic                      parValid,
    input  wire logic                 parReady,
    output logic                      serBit
);

    logic [31:0]           ctrl;
    logic [11:0]           evNum;
    logic [11:0]           wordCnt;
    tdcf_pkg::tdcf_state_t state;
    tdcf_pkg::tdcf_event_t ev;
    logic [3:0]            evChip;
    logic                  wordValid;
    logic                  serBusy;
    logic [35:0]           shiftReg;
    logic [5:0]            bitCnt;
    logic [7:0]            divCnt;
    logic                  serTick;

    logic                  serialSel;
    logic [2:0]            widthRes;
    logic                  slotFree;
    logic                  wordTake;
    logic                  serLoad;
    logic                  stEmit;
    logic                  hitEmit;
    logic                  hitTake;
    logic [31:0]           candWord;
    logic [7:0]            pairWidth;
    logic [16:0]           leadT;
    logic [16:0]           trailT;
    logic [16:0]           diffT;
    logic [16:0]           shiftT;
    tdcf_pkg::tdcf_state_t next_state;

    assign serialSel = ctrl[`TDCF_B_SERIAL];
    assign widthRes  = ctrl[`TDCF_F_WRES_HI:`TDCF_F_WRES_LO];

    // ---------------- AXI4-Lite slave ----------------
    logic wrOk;
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = !s_axi_rvalid;
    assign wrOk = s_axi_awaddr == `TDCF_ADDR_CTRL;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl <= `TDCF_CTRL_RESET;
        end else if (s_axi_awready && wrOk) begin
            for (int b = 0; b < 4; b++) begin
                if (s_axi_wstrb[b]) begin
                    ctrl[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else if (s_axi_awready) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wrOk || s_axi_awaddr == `TDCF_ADDR_STATUS ||
                             s_axi_awaddr == `TDCF_ADDR_EVNUM) ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (s_axi_araddr)
                `TDCF_ADDR_CTRL:   s_axi_rdata <= ctrl;
                `TDCF_ADDR_STATUS: s_axi_rdata <= {16'h0000, wordCnt,
                                                   1'b0, serBusy, wordValid,
                                                   state != tdcf_pkg::TDCF_S_IDLE};
                `TDCF_ADDR_EVNUM:  s_axi_rdata <= {20'h00000, evNum};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- pulse width ----------------
    always_comb begin
        leadT  = {hit.coarse, hit.fine};
        trailT = {hit.trailCoarse, hit.trailFine};
        diffT  = trailT - leadT;
        shiftT = diffT >> widthRes;
        if (trailT < leadT) begin
            pairWidth = 8'h00;
        end else if (shiftT > 17'h000FF) begin
            pairWidth = 8'hFF;
        end else begin
            pairWidth = shiftT[7:0];
        end
    end

    // ---------------- word builder ----------------
    assign serLoad  = serialSel && wordValid && !serBusy;
    assign wordTake = serialSel ? serLoad : (wordValid && parReady);
    assign slotFree = !wordValid || wordTake;
    assign hitEmit  = hit.isPair ? ctrl[`TDCF_B_PAIR] :
                      (hit.leading ? ctrl[`TDCF_B_LEADING] : ctrl[`TDCF_B_TRAILING]);

    always_comb begin
        stEmit   = 1'b0;
        candWord = 32'h0000_0000;
        case (state)
            tdcf_pkg::TDCF_S_HDR: begin
                stEmit   = ctrl[`TDCF_B_HEADER];
                candWord = {tdcf_pkg::TDCF_T_HEADER, evChip, evNum, ev.bunchId};
            end
            tdcf_pkg::TDCF_S_HARD: begin
                stEmit   = ctrl[`TDCF_B_ERRMARK] && (ev.hardErr != 9'h000);
                candWord = {tdcf_pkg::TDCF_T_ERROR, evChip, 15'h0000, ev.hardErr};
            end
            tdcf_pkg::TDCF_S_MEAS: begin
                stEmit = hitValid && hitEmit;
                if (hit.isPair) begin
                    candWord = {tdcf_pkg::TDCF_T_PAIR, evChip, hit.channel,
                                pairWidth, hit.coarse[5:0], hit.fine};
                end else begin
                    candWord = {tdcf_pkg::TDCF_T_SINGLE, evChip, hit.channel, hit.leading,
                                hit.coarseErr | hit.chanSelErr | hit.rejectErr,
                                hit.coarse, hit.fine};
                end
            end
            tdcf_pkg::TDCF_S_FLAG: begin
                stEmit   = ctrl[`TDCF_B_MASK];
                candWord = {tdcf_pkg::TDCF_T_FLAG, evChip, ev.chanFlags};
            end
            tdcf_pkg::TDCF_S_TEMP: begin
                stEmit   = ctrl[`TDCF_B_ERRMARK_TMP] && (ev.tempErr != 9'h000);
                candWord = {tdcf_pkg::TDCF_T_ERROR, evChip, 15'h0000, ev.tempErr};
            end
            tdcf_pkg::TDCF_S_TRL: begin
                stEmit   = ctrl[`TDCF_B_TRAILER];
                candWord = {tdcf_pkg::TDCF_T_TRAIL, evChip, evNum, 12'(wordCnt + 12'h001)};
            end
            tdcf_pkg::TDCF_S_SEP: begin
                stEmit   = ctrl[`TDCF_B_SEPA] && ev.sepPending;
                candWord = {tdcf_pkg::TDCF_T_DEBUG, evChip, 4'h0, 8'h00, ev.sepBunchId};
            end
            tdcf_pkg::TDCF_S_OCC: begin
                stEmit   = ctrl[`TDCF_B_FILL];
                candWord = {tdcf_pkg::TDCF_T_DEBUG, evChip, 4'h1, 11'h000,
                            ev.roFifoFull, ev.l1Occupancy};
            end
            default: begin
                stEmit   = 1'b0;
                candWord = 32'h0000_0000;
            end
        endcase
    end

    assign evReady  = state == tdcf_pkg::TDCF_S_IDLE && !wordValid;
    assign hitReady = state == tdcf_pkg::TDCF_S_MEAS && (slotFree || !hitEmit);
    assign hitTake  = hitReady && hitValid;

    // event sequencing
    always_comb begin
        next_state = state;
        case (state)
            tdcf_pkg::TDCF_S_IDLE: if (evValid && evReady) next_state = tdcf_pkg::TDCF_S_HDR;
            tdcf_pkg::TDCF_S_HDR:  if (!stEmit || slotFree) next_state = tdcf_pkg::TDCF_S_HARD;
            tdcf_pkg::TDCF_S_HARD: begin
                if (!stEmit || slotFree) begin
                    next_state = ev.noHits ? tdcf_pkg::TDCF_S_FLAG : tdcf_pkg::TDCF_S_MEAS;
                end
            end
            tdcf_pkg::TDCF_S_MEAS: if (hitTake && hit.last) next_state = tdcf_pkg::TDCF_S_FLAG;
            tdcf_pkg::TDCF_S_FLAG: if (!stEmit || slotFree) next_state = tdcf_pkg::TDCF_S_TEMP;
            tdcf_pkg::TDCF_S_TEMP: if (!stEmit || slotFree) next_state = tdcf_pkg::TDCF_S_TRL;
            tdcf_pkg::TDCF_S_TRL:  if (!stEmit || slotFree) next_state = tdcf_pkg::TDCF_S_SEP;
            tdcf_pkg::TDCF_S_SEP:  if (!stEmit || slotFree) next_state = tdcf_pkg::TDCF_S_OCC;
            tdcf_pkg::TDCF_S_OCC:  if (!stEmit || slotFree) next_state = tdcf_pkg::TDCF_S_IDLE;
            default:               next_state = tdcf_pkg::TDCF_S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= tdcf_pkg::TDCF_S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // event record, chip id and event number are frozen per event
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ev     <= '0;
            evChip <= 4'h0;
            evNum  <= 12'h000;
        end else if (evReady && evValid) begin
            ev     <= evInfo;
            evChip <= ctrl[`TDCF_F_CHIP_HI:`TDCF_F_CHIP_LO];
        end else if (state == tdcf_pkg::TDCF_S_OCC && next_state == tdcf_pkg::TDCF_S_IDLE) begin
            evNum  <= evNum + 12'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wordValid <= 1'b0;
            parWord   <= 32'h0000_0000;
        end else if (slotFree && stEmit &&
                     (state != tdcf_pkg::TDCF_S_MEAS || hitTake)) begin
            wordValid <= 1'b1;
            parWord   <= candWord;
        end else if (wordTake) begin
            wordValid <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wordCnt <= 12'h000;
        end else if (evReady && evValid) begin
            wordCnt <= 12'h000;
        end else if (slotFree && stEmit &&
                     (state != tdcf_pkg::TDCF_S_MEAS || hitTake)) begin
            wordCnt <= wordCnt + 12'h001;
        end
    end

    assign parValid = wordValid && !serialSel;

    // ---------------- serial link ----------------
    assign serTick = divCnt == 8'h00;

    always_ff @(posedge sys_clk) begin
        if (reset || serTick) begin
            divCnt <= 8'(`TDCF_SER_DIV - 8'h01);
        end else begin
            divCnt <= divCnt - 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            serBusy  <= 1'b0;
            shiftReg <= 36'h0_0000_0000;
            bitCnt   <= 6'h00;
            serBit   <= 1'b0;
        end else if (serLoad) begin
            serBusy  <= 1'b1;
            shiftReg <= {1'b1, parWord, ^parWord, 2'h0};
            bitCnt   <= `TDCF_FRAME_BITS;
        end else if (serBusy && serTick) begin
            serBit   <= shiftReg[35];
            shiftReg <= {shiftReg[34:0], 1'b0};
            bitCnt   <= bitCnt - 6'h01;
            serBusy  <= bitCnt != 6'h01;
        end else if (!serBusy && serTick) begin
            serBit   <= 1'b0;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    logic [11:0] takeCnt;
    logic        seenTrl;
    always_ff @(posedge sys_clk) begin
        if (reset || (evReady && evValid)) begin
            takeCnt <= 12'h000;
            seenTrl <= 1'b0;
        end else if (wordTake) begin
            takeCnt <= takeCnt + 12'h001;
            seenTrl <= seenTrl || parWord[31:28] == tdcf_pkg::TDCF_T_TRAIL;
        end
    end

    property p_type_legal;
        wordValid |-> parWord[31:28] inside {4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'hA, 4'hC};
    endproperty
    a_type_legal: assert property (p_type_legal) else $error("reserved type code");

    property p_chip_id;
        wordValid |-> parWord[27:24] == evChip;
    endproperty
    a_chip_id: assert property (p_chip_id) else $error("chip id field wrong");

    property p_header;
        wordValid && parWord[31:28] == 4'hA |-> parWord[23:12] == evNum;
    endproperty
    a_header: assert property (p_header) else $error("header event number wrong");

    property p_trailer_count;
        wordTake && parWord[31:28] == 4'hC |-> parWord[11:0] == takeCnt + 12'h001;
    endproperty
    a_trailer_count: assert property (p_trailer_count) else $error("trailer count wrong");

    property p_order;
        wordTake && parWord[31:28] inside {4'h3, 4'h4, 4'h2} |-> !seenTrl;
    endproperty
    a_order: assert property (p_order) else $error("data word after trailer");

    property p_frame;
        serLoad |=> shiftReg[35] && !(^shiftReg[34:2]) && shiftReg[1:0] == 2'h0;
    endproperty
    a_frame: assert property (p_frame) else $error("serial frame malformed");

    property p_path;
        serialSel |-> !parValid;
    endproperty
    a_path: assert property (p_path) else $error("parallel word in serial mode");

    property p_width;
        hitValid && trailT < leadT |-> pairWidth == 8'h00;
    endproperty
    a_width: assert property (p_width) else $error("rollover width not zero");

    property p_edge_bit;
        hitTake && !hit.isPair && hitEmit |=> parWord[18] == $past(hit.leading) && wordValid;
    endproperty
    a_edge_bit: assert property (p_edge_bit) else $error("edge bit wrong");

    property p_full_rate;
        !serialSel && wordValid && parReady && state == tdcf_pkg::TDCF_S_MEAS
            && hitValid && hitEmit |=> wordValid;
    endproperty
    a_full_rate: assert property (p_full_rate) else $error("parallel stalled");

    c_pair: cover property (wordTake && parWord[31:28] == 4'h4);
    c_serial: cover property (serLoad ##1 serBusy [*8]);
    c_trailer: cover property (wordTake && parWord[31:28] == 4'hC);
    c_occ: cover property (wordTake && parWord[31:20] == {4'h7, evChip, 4'h1});

endmodule

// ### design/tdcf_params.svh
/*
 * Register offsets, control field positions, reset values and timing counts
 * of the readout word formatter.
 * Assumes byte addressing on a 32-bit AXI4-Lite bus and a 10 MHz sys_clk.
 */
`ifndef TDCF_PARAMS_SVH
`define TDCF_PARAMS_SVH

`define TDCF_ADDR_CTRL      4'h0
`define TDCF_ADDR_STATUS    4'h4
`define TDCF_ADDR_EVNUM     4'h8

`define TDCF_CTRL_RESET     32'h0000_0003

`define TDCF_B_HEADER       0
`define TDCF_B_TRAILER      1
`define TDCF_B_MASK         2
`define TDCF_B_PAIR         3
`define TDCF_B_LEADING      4
`define TDCF_B_TRAILING     5
`define TDCF_B_ERRMARK      6
`define TDCF_B_ERRMARK_TMP  7
`define TDCF_B_SEPA         8
`define TDCF_B_FILL         9
`define TDCF_B_SERIAL       10
`define TDCF_F_WRES_LO      11
`define TDCF_F_WRES_HI      13
`define TDCF_F_CHIP_LO      16
`define TDCF_F_CHIP_HI      19

`define TDCF_CLK_NS         100
`define TDCF_SER_BIT_NS     100
`define TDCF_SER_DIV        8'((`TDCF_SER_BIT_NS + `TDCF_CLK_NS - 1) / `TDCF_CLK_NS)
`define TDCF_FRAME_BITS     6'h24

`endif

// ### design/tdcf_pkg.sv
/*
 * Types of the readout word formatter: word type codes, controller states,
 * and the measurement and event records that enter the block.
 * Assumes tdcf_params.svh is included by the design that uses it.
 */
package tdcf_pkg;

    typedef enum logic [3:0] {
        TDCF_T_FLAG   = 4'h2,
        TDCF_T_SINGLE = 4'h3,
        TDCF_T_PAIR   = 4'h4,
        TDCF_T_ERROR  = 4'h6,
        TDCF_T_DEBUG  = 4'h7,
        TDCF_T_HEADER = 4'hA,
        TDCF_T_TRAIL  = 4'hC
    } tdcf_type_t;

    typedef enum {
        TDCF_S_IDLE, TDCF_S_HDR, TDCF_S_HARD, TDCF_S_MEAS, TDCF_S_FLAG,
        TDCF_S_TEMP, TDCF_S_TRL, TDCF_S_SEP, TDCF_S_OCC
    } tdcf_state_t;

    typedef struct packed {
        logic        last;
        logic        isPair;
        logic        leading;
        logic [4:0]  channel;
        logic [11:0] coarse;
        logic [4:0]  fine;
        logic [11:0] trailCoarse;
        logic [4:0]  trailFine;
        logic        coarseErr;
        logic        chanSelErr;
        logic        rejectErr;
    } tdcf_hit_t;

    typedef struct packed {
        logic [11:0] bunchId;
        logic        noHits;
        logic [8:0]  hardErr;
        logic [8:0]  tempErr;
        logic [23:0] chanFlags;
        logic        sepPending;
        logic [11:0] sepBunchId;
        logic        roFifoFull;
        logic [7:0]  l1Occupancy;
    } tdcf_event_t;

endpackage

// ### dv/tdcf_readout_ctrl.sv
/* readout controller model: takes words off the parallel port, stalling
   every other cycle while slow is high, and deframes the serial line.
   assumes the port and the line share sys_clk, one serial bit per clock. */
module tdcf_readout_ctrl (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        slow,
    input  wire logic [31:0] parWord,
    input  wire logic        parValid,
    output logic             parReady,
    input  wire logic        serBit,
    output logic [31:0]      rxWord,
    output logic             rxStb,
    output logic             rxSer,
    output logic             rxBad
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [34:0] sh;
    logic [5:0]  n;
    always_ff @(posedge sys_clk) begin
        rxStb <= 1'b0;
        if (reset) begin
            n        <= 6'h00;
            parReady <= 1'b0;
        end else begin
            parReady <= !slow || !parReady;
            if (parValid && parReady) begin
                rxWord <= parWord;
                rxStb  <= 1'b1;
                rxSer  <= 1'b0;
                rxBad  <= 1'b0;
            end
            if (n != 6'h00 || serBit) begin
                sh <= {sh[33:0], serBit};
                n  <= (n == 6'h23) ? 6'h00 : n + 6'h01;
            end
            if (n == 6'h23) begin
                rxWord <= sh[33:2];
                rxStb  <= 1'b1;
                rxSer  <= 1'b1;
                rxBad  <= (sh[1] != ^sh[33:2]) || sh[0] || serBit;
            end
        end
    end
endmodule

// ### dv/tdcf_word_formatter_tb.sv
/* testbench of the readout word formatter: events in parallel and serial
   mode, with expected words queued by the driver and checked on receipt.
   assumes the readout controller model as far side. */
`include "tdcf_params.svh"
module tdcf_word_formatter_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0, reset = 1'b1, slow = 1'b0, serMode = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, chip;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, parWord, rxWord, expQ[$];
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, evReady, hitReady;
    logic        evValid = 1'b0, hitValid = 1'b0, parValid, parReady, serBit;
    logic        rxStb, rxSer, rxBad;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [10:0] en;
    logic [2:0]  res;
    logic [11:0] evn = 12'h000, wc;
    logic [16:0] lv;
    integer      seed = 32'heb9f;
    int          error_cnt = 0, comparisons = 0;
    tdcf_pkg::tdcf_event_t evInfo = '0, ev;
    tdcf_pkg::tdcf_hit_t   hit = '0;

    always #50 sys_clk = ~sys_clk;

    tdcf_word_formatter uut (.sys_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .evInfo, .evValid, .evReady, .hit, .hitValid, .hitReady, .parWord,
        .parValid, .parReady, .serBit);
    tdcf_readout_ctrl far (.sys_clk, .reset, .slow, .parWord, .parValid, .parReady,
        .serBit, .rxWord, .rxStb, .rxSer, .rxBad);

    function automatic logic [31:0] rnd();
        return $random(seed);
    endfunction

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic finish_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw = 1'b1, w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end while (aw || w);
        do @(posedge sys_clk); while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, r});
    endtask

    task automatic axr(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge sys_clk);
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
    endtask

    task automatic put(input logic [3:0] t, input logic [23:0] f);
        expQ.push_back({t, chip, f});
        wc = wc + 12'h001;
    endtask

    task automatic evStart(input logic [10:0] e, input logic [2:0] r);
        en = e;
        res = r;
        chip = 4'(rnd());
        serMode = e[10];
        wc = 12'h000;
        axw(`TDCF_ADDR_CTRL, {12'h000, chip, 2'b00, r, e}, 2'b00);
        if (e[0]) put(4'hA, {evn, ev.bunchId});
        if (e[6] && ev.hardErr != 9'h000) put(4'h6, {15'h0000, ev.hardErr});
        evInfo <= ev;
        evValid <= 1'b1;
        do @(posedge sys_clk); while (!evReady);
        evValid <= 1'b0;
    endtask

    task automatic hitGo(input logic last, input logic pr, input logic ld,
                         input logic [4:0] ch, input logic [16:0] l, input logic [16:0] t,
                         input logic [2:0] er);
        logic [16:0] d;
        logic [7:0]  w;
        d = (t - l) >> res;
        w = (t < l) ? 8'h00 : (d > 17'h000FF) ? 8'hFF : d[7:0];
        if (pr && en[3]) put(4'h4, {ch, w, l[10:0]});
        else if (!pr && (ld ? en[4] : en[5])) put(4'h3, {ch, ld, |er, l});
        hit <= {last, pr, ld, ch, l, t, er};
        hitValid <= 1'b1;
        do @(posedge sys_clk); while (!hitReady);
        if (last) hitValid <= 1'b0;
    endtask

    task automatic evEnd();
        if (en[2]) put(4'h2, ev.chanFlags);
        if (en[7] && ev.tempErr != 9'h000) put(4'h6, {15'h0000, ev.tempErr});
        if (en[1]) put(4'hC, {evn, wc + 12'h001});
        if (en[8] && ev.sepPending) put(4'h7, {12'h000, ev.sepBunchId});
        if (en[9]) put(4'h7, {4'h1, 11'h000, ev.roFifoFull, ev.l1Occupancy});
        evn = evn + 12'h001;
        while (expQ.size() != 0) @(posedge sys_clk);
    endtask

    always @(posedge sys_clk) begin
        if (rxStb) begin
            chk({31'h0, rxBad}, 32'h0);
            chk({31'h0, rxSer}, {31'h0, serMode});
            chk(rxWord, expQ.size() ? expQ.pop_front() : 'x);
        end
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        finish_test;
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        axr(`TDCF_ADDR_CTRL, 32'h0000_0003, 2'b00);
        axr(4'hC, 32'h0000_0000, 2'b10);
        axw(4'hC, rnd(), 2'b10);
        axr(`TDCF_ADDR_CTRL, 32'h0000_0003, 2'b00);
        slow <= 1'b1;
        lv = {4'h4, 13'(rnd())};
        ev = {12'(rnd()), 1'b0, 9'h155, 9'h0A3, 24'(rnd()), 1'b1, 12'h000, 1'b0, 8'h00};
        evStart(11'h0FF, 3'd2);
        hitGo(1'b0, 1'b0, 1'b1, 5'h00, lv, lv, 3'b000);
        for (int i = 0; i < 3; i++) hitGo(1'b0, 1'b0, i[0], 5'(i + 21), lv, lv, 3'b001 << i);
        hitGo(1'b0, 1'b1, 1'b1, 5'h0A, lv, lv + 17'h00064, 3'b000);
        hitGo(1'b0, 1'b1, 1'b1, 5'h0B, lv, lv + 17'h01000, 3'b000);
        hitGo(1'b1, 1'b1, 1'b1, 5'h0C, lv, lv - 17'h00001, 3'b000);
        evEnd();
        slow <= 1'b0;
        ev = {12'(rnd()), 1'b0, 9'h1FF, 9'h0FF, 24'(rnd()), 1'b1, 12'(rnd()), 1'b1, 8'(rnd())};
        evStart(11'h713, 3'd0);
        hitGo(1'b0, 1'b0, 1'b0, 5'h05, lv, lv, 3'b000);
        hitGo(1'b1, 1'b0, 1'b1, 5'h1F, lv, lv, 3'b000);
        evEnd();
        ev = {12'(rnd()), 1'b1, 9'h000, 9'h000, 24'h000000, 1'b0, 12'h000, 1'b0, 8'h00};
        evStart(11'h003, 3'd0);
        evEnd();
        axr(`TDCF_ADDR_EVNUM, 32'h0000_0003, 2'b00);
        axr(`TDCF_ADDR_STATUS, 32'h0000_0020, 2'b00);
        finish_test;
    end
endmodule
